// *** core/lps_consts.svh ***
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH
// timing
`define LPS_CLK_PERIOD_NS 4
`define LPS_TICK_NS 8000
`define LPS_TICK_CYC (`LPS_TICK_NS / `LPS_CLK_PERIOD_NS)
// period limits and defaults, in ticks; counter limits; swell threshold off value
`define LPS_PER_INIT 12'h9c4
`define LPS_PER_60HZ 12'h823
`define LPS_PER_MIN 12'h600
`define LPS_PER_MAX 12'hf00
`define LPS_CNT_SAT 12'hfff
`define LPS_DUR_MAX 15'h7fff
`define LPS_SWELL_OFF 10'h3ff
// register byte offsets
`define LPS_OFF_CTRL 8'h00
`define LPS_OFF_SAGTIME 8'h04
`define LPS_OFF_THR0 8'h08
`define LPS_OFF_THR1 8'h0c
`define LPS_OFF_PERIOD 8'h10
`define LPS_OFF_PHASE 8'h14
`define LPS_OFF_HIST 8'h18
`define LPS_OFF_STATUS 8'h1c
`define LPS_OFF_MASK 8'h20
`define LPS_OFF_DUR 8'h24
// control fields
`define LPS_CTRL_REF60 0
`define LPS_CTRL_CLR0 1
`define LPS_CTRL_EXT_LO 4
// status bit of event k = ch*3+kind: 8*ch + 2*kind, +1 for end
`define LPS_PERIOD_OUT_OF_RANGE_BIT 16
`endif

// *** core/lps_pkg.sv ***
package lps_pkg;
	typedef enum logic [1:0] {LPS_IDLE, LPS_QUAL, LPS_ACTIVE} lps_det_state_t;
	typedef struct packed {
		logic [9:0] volt;
		logic [9:0] curr;
	} lps_fund_t;
	typedef struct packed {
		logic [9:0] cswell;
		logic [9:0] vswell;
		logic [9:0] sag;
	} lps_thr_t;
endpackage

// *** core/lps_monitor.sv ***
`timescale 1ns/1ps
`include "lps_consts.svh"

module lps_event_det (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// condition and control
	input wire logic tick,
	input wire logic cond,
	input wire logic [13:0] time_thr,
	input wire logic clr,
	// event state
	output logic [3:0] hist_q,
	output logic [14:0] dur_q,
	output logic active,
	output logic start_q,
	output logic end_q
);
	lps_pkg::lps_det_state_t st_q;
	logic [13:0] tmr_q;
	logic go;
	logic stop;
	logic ovf;
	logic [3:0] hbase;

	// a zero time threshold qualifies at once, which is how swell uses this block
	assign go = cond && ((st_q == lps_pkg::LPS_IDLE && time_thr == 14'h0000) ||
		(st_q == lps_pkg::LPS_QUAL && tick && (tmr_q + 14'h0001) >= time_thr));
	assign stop = (st_q == lps_pkg::LPS_ACTIVE) && !cond;
	assign ovf = (st_q == lps_pkg::LPS_ACTIVE) && cond && tick && dur_q == `LPS_DUR_MAX;
	assign active = st_q == lps_pkg::LPS_ACTIVE;
	// an event landing on a clear cycle is applied on top of the cleared value
	assign hbase = clr ? 4'h0 : hist_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= lps_pkg::LPS_IDLE;
		end else begin
			case (st_q)
				lps_pkg::LPS_IDLE: begin
					if (go)
						st_q <= lps_pkg::LPS_ACTIVE;
					else if (cond)
						st_q <= lps_pkg::LPS_QUAL;
				end
				lps_pkg::LPS_QUAL: begin
					if (go)
						st_q <= lps_pkg::LPS_ACTIVE;
					else if (!cond)
						st_q <= lps_pkg::LPS_IDLE;
				end
				lps_pkg::LPS_ACTIVE: begin
					if (!cond)
						st_q <= lps_pkg::LPS_IDLE;
				end
				default: st_q <= lps_pkg::LPS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst || st_q != lps_pkg::LPS_QUAL)
			tmr_q <= 14'h0000;
		else if (tick)
			tmr_q <= tmr_q + 14'h0001;
	end

	always_ff @(posedge clk) begin
		start_q <= !rst && go;
		end_q <= !rst && stop;
	end

	always_ff @(posedge clk) begin
		if (rst)
			hist_q <= 4'h0;
		else if (go)
			hist_q <= hbase | 4'h1;
		else if (stop)
			hist_q <= {hbase[2:0], 1'b0};
		else if (ovf)
			hist_q <= {hbase[2:0], 1'b1};
		else
			hist_q <= hbase;
	end

	// duration wraps on overflow; the history records that it did
	always_ff @(posedge clk) begin
		if (rst || go)
			dur_q <= 15'h0000;
		else if (clr)
			dur_q <= 15'h0000;
		else if (active && cond && tick)
			dur_q <= dur_q + 15'h0001;
	end

	a_start_hist: assert property (@(posedge clk) disable iff (rst)
		start_q |-> hist_q[0] && active)
		else $error("event start without history bit 0");
	a_end_shift: assert property (@(posedge clk) disable iff (rst)
		stop && !clr |=> end_q && hist_q == {$past(hist_q[2:0]), 1'b0})
		else $error("event end did not shift in zero");
	a_dur_wrap: assert property (@(posedge clk) disable iff (rst)
		ovf && !clr |=> dur_q == 15'h0000 && hist_q == {$past(hist_q[2:0]), 1'b1})
		else $error("duration overflow not recorded");
	a_clear_wipe: assert property (@(posedge clk) disable iff (rst)
		clr && !go && !stop && !ovf |=> hist_q == 4'h0 && dur_q == 15'h0000)
		else $error("clear left history or duration");
	a_qual_wait: assert property (@(posedge clk) disable iff (rst)
		st_q == lps_pkg::LPS_QUAL && !tick |=> !start_q)
		else $error("qualification ended between ticks");
endmodule

module lps_monitor (
	// clock and reset
	input wire logic MCLK,
	input wire logic SRST,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// filter chain inputs, same clock
	input wire logic VOLT_ZERO_CROSS,
	input wire logic [1:0] CURR_ZERO_CROSS,
	input wire lps_pkg::lps_fund_t [1:0] CHAN_FUND,
	// interrupt
	output logic IRQ
);
	logic [10:0] div_q;
	logic tick_q;
	logic ref60_q;
	logic [3:0] clr_ext_q;
	logic [4:0] clr_left_q [2];
	logic [13:0] sag_time_q;
	lps_pkg::lps_thr_t thr_q [2];
	logic [15:0] status_q;
	logic [15:0] mask_q;
	logic [15:0] evt;
	logic [11:0] per_hist_q [8];
	logic [14:0] sum_q;
	logic [2:0] idx_q;
	logic [11:0] meas_q;
	logic zc_q;
	logic zc_edge;
	logic range_err_q;
	logic period_out_of_range;
	logic [11:0] period_q;
	logic zc_seen_q;
	logic ref_wr;
	logic [1:0] czc_q;
	logic [1:0] ph_run_q;
	logic [11:0] ph_cnt_q [2];
	logic [11:0] phase_q [2];
	logic [3:0] hist [6];
	logic [14:0] dur [6];
	logic [5:0] act;
	logic [5:0] st_p;
	logic [5:0] en_p;
	logic [31:0] rd_mux;

	assign ref_wr = WR && ADDR == `LPS_OFF_CTRL && WDATA[`LPS_CTRL_REF60] != ref60_q;
	assign zc_edge = VOLT_ZERO_CROSS && !zc_q;
	assign period_out_of_range = range_err_q || act[0] || act[3];

	// 8 us tick
	always_ff @(posedge MCLK) begin
		if (SRST || div_q == 11'(`LPS_TICK_CYC - 1))
			div_q <= 11'h000;
		else
			div_q <= div_q + 11'h001;
		tick_q <= !SRST && div_q == 11'(`LPS_TICK_CYC - 1);
	end

	// configuration
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			ref60_q <= 1'b0;
			clr_ext_q <= 4'h0;
			sag_time_q <= 14'h0000;
			mask_q <= 16'h0000;
			thr_q[0] <= {`LPS_SWELL_OFF, `LPS_SWELL_OFF, 10'h000};
			thr_q[1] <= {`LPS_SWELL_OFF, `LPS_SWELL_OFF, 10'h000};
		end else if (WR) begin
			case (ADDR)
				`LPS_OFF_CTRL: begin
					ref60_q <= WDATA[`LPS_CTRL_REF60];
					clr_ext_q <= WDATA[`LPS_CTRL_EXT_LO +: 4];
				end
				`LPS_OFF_SAGTIME: sag_time_q <= WDATA[13:0];
				`LPS_OFF_THR0: thr_q[0] <= WDATA[29:0];
				`LPS_OFF_THR1: thr_q[1] <= WDATA[29:0];
				`LPS_OFF_MASK: mask_q <= WDATA[15:0];
				default: ;
			endcase
		end
	end

	// clear pulse: held for extension+1 ticks so running counters see it
	for (genvar c = 0; c < 2; c++) begin : g_clr
		always_ff @(posedge MCLK) begin
			if (SRST)
				clr_left_q[c] <= 5'h00;
			else if (WR && ADDR == `LPS_OFF_CTRL && WDATA[`LPS_CTRL_CLR0 + c])
				clr_left_q[c] <= {1'b0, WDATA[`LPS_CTRL_EXT_LO +: 4]} + 5'h01;
			else if (tick_q && clr_left_q[c] != 5'h00)
				clr_left_q[c] <= clr_left_q[c] - 5'h01;
		end
	end

	// period measurement
	always_ff @(posedge MCLK) begin
		zc_q <= !SRST && VOLT_ZERO_CROSS;
		zc_seen_q <= !SRST && (zc_seen_q || zc_edge);
		if (SRST || zc_edge)
			meas_q <= 12'h000;
		else if (tick_q && meas_q != `LPS_CNT_SAT)
			meas_q <= meas_q + 12'h001;
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			range_err_q <= 1'b0;
		else if (zc_edge && zc_seen_q)
			range_err_q <= meas_q < `LPS_PER_MIN || meas_q > `LPS_PER_MAX;
		else if (meas_q > `LPS_PER_MAX)
			range_err_q <= 1'b1;
	end

	always_ff @(posedge MCLK) begin
		if (SRST || ref_wr) begin
			for (int i = 0; i < 8; i++)
				per_hist_q[i] <= ref_wr ? (WDATA[`LPS_CTRL_REF60] ? `LPS_PER_60HZ : `LPS_PER_INIT)
					: `LPS_PER_INIT;
			sum_q <= ref_wr ? (WDATA[`LPS_CTRL_REF60] ? {`LPS_PER_60HZ, 3'b000} : {`LPS_PER_INIT, 3'b000})
				: {`LPS_PER_INIT, 3'b000};
			idx_q <= 3'h0;
		end else if (zc_edge && zc_seen_q && meas_q >= `LPS_PER_MIN && meas_q <= `LPS_PER_MAX) begin
			per_hist_q[idx_q] <= meas_q;
			sum_q <= sum_q - {3'b000, per_hist_q[idx_q]} + {3'b000, meas_q};
			idx_q <= idx_q + 3'h1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			period_q <= `LPS_PER_INIT;
		else if (ref_wr)
			period_q <= WDATA[`LPS_CTRL_REF60] ? `LPS_PER_60HZ : `LPS_PER_INIT;
		else if (!period_out_of_range)
			period_q <= sum_q[14:3];
	end

	// phase delay per channel
	for (genvar c = 0; c < 2; c++) begin : g_phase
		always_ff @(posedge MCLK) begin
			czc_q[c] <= !SRST && CURR_ZERO_CROSS[c];
			if (SRST) begin
				ph_run_q[c] <= 1'b0;
				ph_cnt_q[c] <= 12'h000;
				phase_q[c] <= 12'h000;
			end else if (zc_edge) begin
				ph_run_q[c] <= 1'b1;
				ph_cnt_q[c] <= 12'h000;
			end else if (ph_run_q[c] && CURR_ZERO_CROSS[c] && !czc_q[c]) begin
				ph_run_q[c] <= 1'b0;
				if (!period_out_of_range)
					phase_q[c] <= ph_cnt_q[c];
			end else if (ph_run_q[c] && tick_q && ph_cnt_q[c] != `LPS_CNT_SAT) begin
				ph_cnt_q[c] <= ph_cnt_q[c] + 12'h001;
			end
		end
	end

	// detectors: k = ch*3 + kind, kind 0 sag, 1 voltage swell, 2 current swell
	for (genvar k = 0; k < 6; k++) begin : g_det
		logic cond;
		if (k % 3 == 0)
			assign cond = CHAN_FUND[k / 3].volt < thr_q[k / 3].sag;
		else if (k % 3 == 1)
			assign cond = CHAN_FUND[k / 3].volt > thr_q[k / 3].vswell;
		else
			assign cond = CHAN_FUND[k / 3].curr > thr_q[k / 3].cswell;
		lps_event_det u_det (
			.clk(MCLK),
			.rst(SRST),
			.tick(tick_q),
			.cond(cond),
			.time_thr(k % 3 == 0 ? sag_time_q : 14'h0000),
			.clr(clr_left_q[k / 3] != 5'h00),
			.hist_q(hist[k]),
			.dur_q(dur[k]),
			.active(act[k]),
			.start_q(st_p[k]),
			.end_q(en_p[k])
		);
		assign evt[8 * (k / 3) + 2 * (k % 3)] = st_p[k];
		assign evt[8 * (k / 3) + 2 * (k % 3) + 1] = en_p[k];
	end
	assign evt[7:6] = 2'b00;
	assign evt[15:14] = 2'b00;

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge MCLK) begin
		if (SRST)
			status_q <= 16'h0000;
		else
			status_q <= (status_q & ~((WR && ADDR == `LPS_OFF_STATUS) ? WDATA[15:0] : 16'h0000))
				| evt;
		IRQ <= !SRST && |(status_q & mask_q);
	end

	always_comb begin
		rd_mux = 32'h00000000;
		case (ADDR)
			`LPS_OFF_CTRL: rd_mux = {24'h000000, clr_ext_q, 1'b0, clr_left_q[1] != 5'h00,
				clr_left_q[0] != 5'h00, ref60_q};
			`LPS_OFF_SAGTIME: rd_mux = {18'h00000, sag_time_q};
			`LPS_OFF_THR0: rd_mux = {2'b00, thr_q[0]};
			`LPS_OFF_THR1: rd_mux = {2'b00, thr_q[1]};
			`LPS_OFF_PERIOD: rd_mux = {15'h0000, period_out_of_range, 4'h0, period_q};
			`LPS_OFF_PHASE: rd_mux = {4'h0, phase_q[1], 4'h0, phase_q[0]};
			`LPS_OFF_HIST: rd_mux = {4'h0, hist[5], hist[4], hist[3], 4'h0, hist[2], hist[1], hist[0]};
			`LPS_OFF_STATUS: rd_mux = {16'h0000, status_q};
			`LPS_OFF_MASK: rd_mux = {16'h0000, mask_q};
			default: begin
				for (int k = 0; k < 6; k++)
					if (ADDR == 8'(`LPS_OFF_DUR + 4 * k))
						rd_mux = {17'h00000, dur[k]};
			end
		endcase
	end

	always_ff @(posedge MCLK) begin
		RDATA <= (!SRST && RD) ? rd_mux : 32'h00000000;
	end

	sequence s_clr_write(c);
		WR && ADDR == `LPS_OFF_CTRL && WDATA[`LPS_CTRL_CLR0 + c];
	endsequence
	sequence s_clr_held(c);
		clr_left_q[c] != 5'h00;
	endsequence

	a_period_freeze: assert property (@(posedge MCLK) disable iff (SRST)
		period_out_of_range && !ref_wr |=> period_q == $past(period_q))
		else $error("period moved during period error");
	a_phase_hold: assert property (@(posedge MCLK) disable iff (SRST)
		period_out_of_range |=> phase_q[0] == $past(phase_q[0]) && phase_q[1] == $past(phase_q[1]))
		else $error("phase moved during period error");
	a_period_range: assert property (@(posedge MCLK) disable iff (SRST)
		zc_edge && zc_seen_q && (meas_q < `LPS_PER_MIN || meas_q > `LPS_PER_MAX) |=> period_out_of_range)
		else $error("out of range period not flagged");
	a_sag_period_out_of_range: assert property (@(posedge MCLK) disable iff (SRST)
		(act[0] || act[3]) && RD && ADDR == `LPS_OFF_PERIOD |=> RDATA[16])
		else $error("sag did not raise period error");
	a_irq_mask: assert property (@(posedge MCLK) disable iff (SRST)
		##1 IRQ == |($past(status_q) & $past(mask_q)))
		else $error("interrupt not gated by mask");
	a_clear_hold: assert property (@(posedge MCLK) disable iff (SRST)
		s_clr_write(0) ##1 (!tick_q && !WR) |=> clr_left_q[0] == $past(clr_left_q[0]))
		else $error("clear pulse shortened between ticks");
	a_clear_start: assert property (@(posedge MCLK) disable iff (SRST)
		s_clr_write(1) |=> s_clr_held(1))
		else $error("clear pulse too short");
	a_status_sticky: assert property (@(posedge MCLK) disable iff (SRST)
		st_p[0] |=> status_q[0])
		else $error("sag start status lost");
	a_ref_preload: assert property (@(posedge MCLK) disable iff (SRST)
		ref_wr && WDATA[`LPS_CTRL_REF60] |=> period_q == `LPS_PER_60HZ)
		else $error("reference preload missing");
endmodule

// *** tb/lps_tb.sv ***
`timescale 1ns/1ps
`include "lps_consts.svh"
module tb;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic vzc = 1'b0;
	logic [1:0] czc = 2'b00;
	lps_pkg::lps_fund_t [1:0] fund = {10'h200, 10'h010, 10'h200, 10'h010};
	logic irq;
	int mismatches = 0;
	int samples_checked = 0;
	logic [31:0] d;
	logic [31:0] ph;

	always #2 mclk = ~mclk;

	lps_monitor lps_monitor_inst (
		.MCLK(mclk),
		.SRST(srst),
		.ADDR(addr),
		.WDATA(wdata),
		.WR(wr),
		.RD(rd),
		.RDATA(rdata),
		.VOLT_ZERO_CROSS(vzc),
		.CURR_ZERO_CROSS(czc),
		.CHAN_FUND(fund),
		.IRQ(irq)
	);

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// tick phase against the bus is unknown, so tick counts get a window
	task automatic chk_range(input logic [11:0] got, input int lo, input int hi,
		input string msg);
		samples_checked++;
		if ((^got === 1'bx) || got < lo || got > hi) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h", $time, msg, got);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] v;
		rd_reg(a, v);
		chk(v, exp, msg);
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge mclk);
		mismatches++;
		$display("wrong value at %0t: watchdog expired", $time);
		test_done;
	end

	initial begin
		cyc(4);
		srst <= 1'b0;
		// reset state
		rd_chk(`LPS_OFF_PERIOD, 32'h000009c4, "period reset");
		rd_chk(`LPS_OFF_PHASE, 32'h0, "phase reset");
		rd_chk(`LPS_OFF_THR0, 32'h3ffffc00, "thr0 reset");
		rd_chk(`LPS_OFF_HIST, 32'h0, "hist reset");
		rd_chk(8'h40, 32'h0, "unmapped read");
		wr_reg(`LPS_OFF_PERIOD, 32'h00000123);
		rd_chk(`LPS_OFF_PERIOD, 32'h000009c4, "period read only");
		// reference frequency preload
		wr_reg(`LPS_OFF_CTRL, 32'h1);
		rd_chk(`LPS_OFF_PERIOD, 32'h00000823, "60 Hz preload");
		wr_reg(`LPS_OFF_CTRL, 32'h0);
		rd_chk(`LPS_OFF_PERIOD, 32'h000009c4, "50 Hz preload");
		// phase delay of three ticks on both channels
		@(posedge mclk) vzc <= 1'b1;
		cyc(6000);
		@(posedge mclk) czc <= 2'b11;
		cyc(10);
		rd_reg(`LPS_OFF_PHASE, ph);
		chk_range(ph[11:0], 2, 4, "phase ch0");
		chk_range(ph[27:16], 2, 4, "phase ch1");
		@(posedge mclk) vzc <= 1'b0;
		czc <= 2'b00;
		// sag with a time threshold of three ticks
		wr_reg(`LPS_OFF_SAGTIME, 32'h3);
		wr_reg(`LPS_OFF_MASK, 32'h1);
		wr_reg(`LPS_OFF_THR0, 32'h3ffffd00);
		@(posedge mclk) fund[0].volt <= 10'h080;
		cyc(100);
		rd_chk(`LPS_OFF_HIST, 32'h0, "sag not yet");
		cyc(8000);
		rd_chk(`LPS_OFF_HIST, 32'h1, "sag start hist");
		rd_chk(`LPS_OFF_STATUS, 32'h1, "sag start status");
		chk({31'h0, irq}, 32'h1, "sag irq");
		rd_chk(`LPS_OFF_PERIOD, 32'h000109c4, "sag period error");
		// zero crossings during the error must not move the phase
		@(posedge mclk) vzc <= 1'b1;
		cyc(2000);
		@(posedge mclk) czc <= 2'b11;
		cyc(10);
		rd_chk(`LPS_OFF_PHASE, ph, "phase held");
		@(posedge mclk) fund[0].volt <= 10'h200;
		cyc(10);
		rd_chk(`LPS_OFF_HIST, 32'h2, "sag end hist");
		rd_chk(`LPS_OFF_STATUS, 32'h3, "sag end status");
		wr_reg(`LPS_OFF_STATUS, 32'h3);
		rd_chk(`LPS_OFF_STATUS, 32'h0, "status w1c");
		// sag threshold zero disables sag, voltage swell raises masked irq
		@(posedge mclk) fund[0].volt <= 10'h050;
		wr_reg(`LPS_OFF_MASK, 32'h4);
		wr_reg(`LPS_OFF_THR0, 32'h3ff40000);
		cyc(4100);
		rd_chk(`LPS_OFF_HIST, 32'h2, "sag disabled");
		@(posedge mclk) fund[0].volt <= 10'h200;
		cyc(4);
		rd_chk(`LPS_OFF_HIST, 32'h12, "vswell start hist");
		rd_chk(`LPS_OFF_STATUS, 32'h4, "vswell start status");
		chk({31'h0, irq}, 32'h1, "vswell irq");
		cyc(6000);
		@(posedge mclk) fund[0].volt <= 10'h080;
		cyc(4);
		rd_chk(`LPS_OFF_HIST, 32'h22, "vswell end hist");
		rd_chk(`LPS_OFF_STATUS, 32'hc, "vswell end status");
		rd_reg(8'h28, d);
		chk_range(d[11:0], 2, 4, "vswell duration");
		wr_reg(`LPS_OFF_STATUS, 32'hc);
		cyc(3);
		chk({31'h0, irq}, 32'h0, "irq after clear");
		// current swell on channel 1, start and end status both not masked
		wr_reg(`LPS_OFF_THR1, 32'h080ffc00);
		@(posedge mclk) fund[1].curr <= 10'h100;
		cyc(4);
		rd_chk(`LPS_OFF_HIST, 32'h01000022, "cswell start hist");
		@(posedge mclk) fund[1].curr <= 10'h010;
		cyc(4);
		rd_chk(`LPS_OFF_HIST, 32'h02000022, "cswell end hist");
		rd_chk(`LPS_OFF_STATUS, 32'h3000, "cswell status");
		chk({31'h0, irq}, 32'h0, "unmasked irq");
		// clear channel 0 stretched by one tick, so the readback cannot race a tick
		wr_reg(`LPS_OFF_CTRL, 32'h12);
		rd_chk(`LPS_OFF_CTRL, 32'h12, "clear pending");
		cyc(4100);
		rd_chk(`LPS_OFF_CTRL, 32'h10, "clear self reset");
		rd_chk(`LPS_OFF_HIST, 32'h02000000, "ch0 cleared");
		rd_chk(8'h28, 32'h0, "ch0 duration cleared");
		// clear channel 1 stretched by two ticks
		wr_reg(`LPS_OFF_CTRL, 32'h24);
		cyc(2100);
		rd_chk(`LPS_OFF_CTRL, 32'h24, "clear stretched");
		cyc(6100);
		rd_chk(`LPS_OFF_CTRL, 32'h20, "stretched clear done");
		rd_chk(`LPS_OFF_HIST, 32'h0, "ch1 cleared");
		test_done;
	end
endmodule
